// [common/dce_pkg.sv]
// Functional notes
// - Comparator runs only while its setup bit 15 is one.
// - Bit 14 puts the raw, unsynchronised result onto its output pin.
// - Result bit 8 is plus above minus, flipped when bit 13 is set.
// - Bit 12 set selects the comparator's low-power mode.
// - Chosen event sets flag bit 9; further triggers blocked until cleared.
// - Edge select 11 gives an event on any result change.
// - Edge select 10: falling edge, or rising when inverted.
// - Edge select 01: rising edge, or falling when inverted.
// - Edge select 00 gives no trigger, event or interrupt.
// - Bit 4 picks ladder output, else input pin A, for plus input.
// - Minus select: 11 half band-gap, 10 pin D, 01 pin C, 00 pin B.
// - Status bit 15 stops all comparators while the device idles.
// - Status bits 9 and 8 mirror event flags of comparators two and one.
// - Status bits 1 and 0 mirror results of comparators two and one.
// - Ladder has two ranges of sixteen levels, chosen by four bits.
// - Ladder bit 7 powers the reference circuit on.
// - Ladder bit 6 connects the reference level to its pin.
// - Range bit 5: one set gives span/24 steps, else quarter plus span/32.
// - Source bit 4: external reference pins with offset, else analog supplies.
`default_nettype none
package dce_pkg;
	localparam int unsigned ADDR_W = 2;
	localparam int unsigned DATA_W = 16;
	localparam logic [ADDR_W-1:0] ADDR_SETUP_ONE = 2'h0;
	localparam logic [ADDR_W-1:0] ADDR_SETUP_TWO = 2'h1;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 2'h2;
	localparam logic [ADDR_W-1:0] ADDR_LADDER = 2'h3;
	localparam int unsigned BIT_ON = 15;
	localparam int unsigned BIT_PIN_DRIVE = 14;
	localparam int unsigned BIT_INVERT = 13;
	localparam int unsigned BIT_LOW_POWER = 12;
	localparam int unsigned BIT_EVENT = 9;
	localparam int unsigned BIT_RESULT = 8;
	localparam int unsigned BIT_EDGE_HI = 7;
	localparam int unsigned BIT_EDGE_LO = 6;
	localparam int unsigned BIT_PLUS_SEL = 4;
	localparam int unsigned BIT_MINUS_HI = 1;
	localparam int unsigned BIT_MINUS_LO = 0;
	localparam int unsigned BIT_IDLE_STOP = 15;
	localparam int unsigned BIT_EVT_MIRROR_ONE = 8;
	localparam int unsigned BIT_OUT_MIRROR_ONE = 0;
	localparam int unsigned BIT_LADDER_POWER = 7;
	localparam int unsigned BIT_LADDER_PIN = 6;
	localparam int unsigned BIT_LADDER_RANGE = 5;
	localparam int unsigned BIT_LADDER_SOURCE = 4;
	localparam int unsigned LADDER_LEVEL_W = 4;
	localparam logic [DATA_W-1:0] SETUP_WMASK = 16'hf2d3;
	localparam logic [DATA_W-1:0] LADDER_WMASK = 16'h00ff;
	localparam logic [DATA_W-1:0] RESET_VALUE = 16'h0000;
	localparam logic [1:0] EDGE_NONE = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_ANY = 2'h3;
	localparam logic [1:0] MINUS_PIN_B = 2'h0;
	localparam logic [1:0] MINUS_PIN_C = 2'h1;
	localparam logic [1:0] MINUS_PIN_D = 2'h2;
	localparam logic [1:0] MINUS_HALF_BANDGAP = 2'h3;
	localparam int unsigned NUM_CMP = 2;
	localparam int unsigned SYNC_STAGES = 3;
endpackage
`default_nettype wire

// [hw/dce_sync.sv]
`default_nettype none
// Three-stage pin synchroniser; output changes once stages two and three agree
module dce_sync (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic async_in,
	output logic sync_out
);
	logic [dce_pkg::SYNC_STAGES-1:0] stage_q;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			stage_q <= '0;
		end else begin
			stage_q <= {stage_q[dce_pkg::SYNC_STAGES-2:0], async_in};
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sync_out <= 1'b0;
		end else if (stage_q[1] == stage_q[2]) begin
			sync_out <= stage_q[2];
		end
	end
endmodule
`default_nettype wire

// [hw/dce_top.sv]
// The plain strobed port and the address map were left to the implementer.
`default_nettype none
// Digital control for two comparators and a reference ladder
module dce_top (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [dce_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [dce_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [dce_pkg::DATA_W-1:0] reg_rdata,
	input wire logic device_idle,
	input wire logic [dce_pkg::NUM_CMP-1:0] analog_result,
	output logic [dce_pkg::NUM_CMP-1:0] cmp_power,
	output logic [dce_pkg::NUM_CMP-1:0] cmp_low_power,
	output logic [dce_pkg::NUM_CMP-1:0] plus_select_ladder,
	output logic [1:0] minus_select_one,
	output logic [1:0] minus_select_two,
	output logic [dce_pkg::NUM_CMP-1:0] result_pin,
	output logic [dce_pkg::NUM_CMP-1:0] result_pin_oe,
	output logic ladder_power,
	output logic ladder_pin_drive,
	output logic ladder_range,
	output logic ladder_source,
	output logic [dce_pkg::LADDER_LEVEL_W-1:0] ladder_level,
	output logic [dce_pkg::NUM_CMP-1:0] event_irq,
	output logic [dce_pkg::NUM_CMP-1:0] event_trigger
);
	logic [dce_pkg::DATA_W-1:0] setup_q [dce_pkg::NUM_CMP];
	logic [dce_pkg::DATA_W-1:0] ladder_q;
	logic idle_stop_q;
	logic [dce_pkg::NUM_CMP-1:0] result_q;
	logic [dce_pkg::NUM_CMP-1:0] event_q;
	logic [dce_pkg::NUM_CMP-1:0] event_prev_q;
	logic [dce_pkg::NUM_CMP-1:0] running;
	logic [dce_pkg::NUM_CMP-1:0] raw_result;
	logic [dce_pkg::NUM_CMP-1:0] sync_result;
	logic [dce_pkg::NUM_CMP-1:0] event_hit;
	logic [dce_pkg::NUM_CMP-1:0] setup_write;
	logic [dce_pkg::DATA_W-1:0] rdata_d;
	logic [dce_pkg::DATA_W-1:0] status_word;
	logic idle_sync;
	dce_sync u_idle_sync (
		.clock(clock),
		.rst_n(rst_n),
		.async_in(device_idle),
		.sync_out(idle_sync)
	);
	// All comparators halt in idle when the stop bit is set
	always_comb begin
		for (int k = 0; k < dce_pkg::NUM_CMP; k++) begin
			running[k] = setup_q[k][dce_pkg::BIT_ON] && !(idle_stop_q && idle_sync);
		end
	end
	assign setup_write[0] = reg_write && (reg_addr == dce_pkg::ADDR_SETUP_ONE);
	assign setup_write[1] = reg_write && (reg_addr == dce_pkg::ADDR_SETUP_TWO);
	genvar i;
	generate
		for (i = 0; i < dce_pkg::NUM_CMP; i++) begin : g_cmp
			logic inv;
			logic [1:0] edge_sel;
			logic rise;
			logic fall;
			assign inv = setup_q[i][dce_pkg::BIT_INVERT];
			assign edge_sel = setup_q[i][dce_pkg::BIT_EDGE_HI:dce_pkg::BIT_EDGE_LO];
			// Raw analog result with polarity, gated by enable
			assign raw_result[i] = running[i] && (analog_result[i] ^ inv);
			// Unsynchronised path to the pin
			assign result_pin[i] = raw_result[i];
			assign result_pin_oe[i] = setup_q[i][dce_pkg::BIT_PIN_DRIVE];
			assign cmp_power[i] = running[i];
			assign cmp_low_power[i] = setup_q[i][dce_pkg::BIT_LOW_POWER];
			assign plus_select_ladder[i] = setup_q[i][dce_pkg::BIT_PLUS_SEL];
			dce_sync u_res_sync (
				.clock(clock),
				.rst_n(rst_n),
				.async_in(raw_result[i]),
				.sync_out(sync_result[i])
			);
			assign rise = !result_q[i] && sync_result[i];
			assign fall = result_q[i] && !sync_result[i];
			// Edges are judged on the polarity-applied output; inversion swaps the edge that counts
			always_comb begin
				case (edge_sel)
					dce_pkg::EDGE_ANY: event_hit[i] = rise || fall;
					dce_pkg::EDGE_FALL: event_hit[i] = inv ? rise : fall;
					dce_pkg::EDGE_RISE: event_hit[i] = inv ? fall : rise;
					dce_pkg::EDGE_NONE: event_hit[i] = 1'b0;
					default: event_hit[i] = 1'b0;
				endcase
			end
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					result_q[i] <= 1'b0;
				end else begin
					result_q[i] <= sync_result[i];
				end
			end
			// Set wins over a software clear in the same cycle
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					event_q[i] <= 1'b0;
				end else if (running[i] && event_hit[i]) begin
					event_q[i] <= 1'b1;
				end else if (setup_write[i]) begin
					event_q[i] <= reg_wdata[dce_pkg::BIT_EVENT];
				end
			end
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					event_prev_q[i] <= 1'b0;
				end else begin
					event_prev_q[i] <= event_q[i];
				end
			end
			// Pulse only on the flag's rising edge; a set flag blocks more
			assign event_irq[i] = event_q[i] && !event_prev_q[i];
			assign event_trigger[i] = event_q[i] && !event_prev_q[i];
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					setup_q[i] <= dce_pkg::RESET_VALUE;
				end else if (setup_write[i]) begin
					setup_q[i] <= reg_wdata & dce_pkg::SETUP_WMASK;
				end
			end
		end
	endgenerate
	assign minus_select_one = setup_q[0][dce_pkg::BIT_MINUS_HI:dce_pkg::BIT_MINUS_LO];
	assign minus_select_two = setup_q[1][dce_pkg::BIT_MINUS_HI:dce_pkg::BIT_MINUS_LO];
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			idle_stop_q <= 1'b0;
		end else if (reg_write && reg_addr == dce_pkg::ADDR_STATUS) begin
			idle_stop_q <= reg_wdata[dce_pkg::BIT_IDLE_STOP];
		end
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ladder_q <= dce_pkg::RESET_VALUE;
		end else if (reg_write && reg_addr == dce_pkg::ADDR_LADDER) begin
			ladder_q <= reg_wdata & dce_pkg::LADDER_WMASK;
		end
	end
	assign ladder_power = ladder_q[dce_pkg::BIT_LADDER_POWER];
	assign ladder_pin_drive = ladder_q[dce_pkg::BIT_LADDER_PIN];
	assign ladder_range = ladder_q[dce_pkg::BIT_LADDER_RANGE];
	assign ladder_source = ladder_q[dce_pkg::BIT_LADDER_SOURCE];
	assign ladder_level = ladder_q[dce_pkg::LADDER_LEVEL_W-1:0];
	always_comb begin
		status_word = dce_pkg::RESET_VALUE;
		status_word[dce_pkg::BIT_IDLE_STOP] = idle_stop_q;
		status_word[dce_pkg::BIT_EVT_MIRROR_ONE +: dce_pkg::NUM_CMP] = event_q;
		status_word[dce_pkg::BIT_OUT_MIRROR_ONE +: dce_pkg::NUM_CMP] = result_q;
	end
	always_comb begin
		rdata_d = dce_pkg::RESET_VALUE;
		case (reg_addr)
			dce_pkg::ADDR_SETUP_ONE: begin
				rdata_d = setup_q[0];
				rdata_d[dce_pkg::BIT_EVENT] = event_q[0];
				rdata_d[dce_pkg::BIT_RESULT] = result_q[0];
			end
			dce_pkg::ADDR_SETUP_TWO: begin
				rdata_d = setup_q[1];
				rdata_d[dce_pkg::BIT_EVENT] = event_q[1];
				rdata_d[dce_pkg::BIT_RESULT] = result_q[1];
			end
			dce_pkg::ADDR_STATUS: rdata_d = status_word;
			dce_pkg::ADDR_LADDER: rdata_d = ladder_q;
			default: rdata_d = dce_pkg::RESET_VALUE;
		endcase
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= dce_pkg::RESET_VALUE;
		end else if (reg_read) begin
			reg_rdata <= rdata_d;
		end else begin
			reg_rdata <= dce_pkg::RESET_VALUE;
		end
	end
endmodule
`default_nettype wire

// [testbench/dce_top_properties.sv]
`default_nettype none
module dce_top_properties (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [1:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	input wire logic [1:0] cmp_power,
	input wire logic [1:0] cmp_low_power,
	input wire logic [1:0] plus_select_ladder,
	input wire logic [1:0] minus_select_one,
	input wire logic [1:0] result_pin_oe,
	input wire logic ladder_power,
	input wire logic ladder_pin_drive,
	input wire logic ladder_range,
	input wire logic ladder_source,
	input wire logic [3:0] ladder_level,
	input wire logic [1:0] event_irq,
	input wire logic [1:0] event_trigger
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	logic wr_one;
	logic wr_ladder;
	assign wr_one = reg_write && reg_addr == dce_pkg::ADDR_SETUP_ONE;
	assign wr_ladder = reg_write && reg_addr == dce_pkg::ADDR_LADDER;
	a_power_off: assert property (wr_one && !reg_wdata[15] |=> !cmp_power[0])
		else $error("comparator runs after turn off");
	a_drive_enable: assert property (wr_one |=> result_pin_oe[0] == $past(reg_wdata[14]))
		else $error("pin drive enable wrong");
	a_low_power: assert property (wr_one |=> cmp_low_power[0] == $past(reg_wdata[12]))
		else $error("low power select wrong");
	a_plus_route: assert property (wr_one |=> plus_select_ladder[0] == $past(reg_wdata[4]))
		else $error("plus input select wrong");
	a_minus_route: assert property (wr_one |=> minus_select_one == $past(reg_wdata[1:0]))
		else $error("minus input select wrong");
	a_ladder_fields: assert property (wr_ladder |=>
		{ladder_power, ladder_pin_drive, ladder_range, ladder_source, ladder_level} == $past(reg_wdata[7:0]))
		else $error("ladder fields wrong");
	a_event_single: assert property (event_irq[0] |=> !event_irq[0])
		else $error("event pulse longer than one cycle");
	a_trigger_pair: assert property (event_irq == event_trigger)
		else $error("trigger and interrupt differ");
	cover property (event_irq[0]);
	cover property (event_irq[1]);
	cover property (wr_ladder);
endmodule
bind dce_top dce_top_properties i_dce_top_properties (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_write,
	.cmp_power, .cmp_low_power, .plus_select_ladder, .minus_select_one, .result_pin_oe, .ladder_power,
	.ladder_pin_drive, .ladder_range, .ladder_source, .ladder_level, .event_irq, .event_trigger);
`default_nettype wire

// [testbench/dce_analog_model.sv]
`default_nettype none
module dce_analog_model (
	input wire logic [1:0] cmp_power,
	input wire logic [1:0] plus_select_ladder,
	input wire logic [1:0] minus_select_one,
	input wire logic [1:0] minus_select_two,
	input wire logic ladder_power,
	input wire logic ladder_range,
	input wire logic ladder_source,
	input wire logic [3:0] ladder_level,
	input wire logic [15:0] pin_a,
	input wire logic [15:0] pin_b,
	input wire logic [15:0] pin_c,
	input wire logic [15:0] pin_d,
	output logic [1:0] analog_result
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] HALF_BANDGAP = 8'h60;
	localparam logic [7:0] REF_LOW = 8'h10;
	logic [7:0] ladder_v;
	logic [7:0] plus_v;
	logic [7:0] minus_v;
	always_comb begin
		ladder_v = 8'h00;
		if (ladder_power)
			ladder_v = ladder_range ? 8'(ladder_level * 10) : 8'(64 + ladder_level * 8);
		if (ladder_power && ladder_source)
			ladder_v = ladder_v + REF_LOW;
		for (int i = 0; i < 2; i++) begin
			plus_v = plus_select_ladder[i] ? ladder_v : pin_a[8*i +: 8];
			case (i == 0 ? minus_select_one : minus_select_two)
				2'h0: minus_v = pin_b[8*i +: 8];
				2'h1: minus_v = pin_c[8*i +: 8];
				2'h2: minus_v = pin_d[8*i +: 8];
				default: minus_v = HALF_BANDGAP;
			endcase
			analog_result[i] = cmp_power[i] && plus_v > minus_v;
		end
	end
endmodule
`default_nettype wire

// [testbench/test_dual_comparator_event_ctrl.sv]
`default_nettype none
module test_dual_comparator_event_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0, rst_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0, device_idle = 1'b0;
	logic [1:0] reg_addr = 2'h0;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata, pin_a = 16'h4040;
	logic [1:0] analog_result, cmp_power, cmp_low_power, plus_select_ladder, minus_select_one, minus_select_two;
	logic [1:0] result_pin, result_pin_oe, event_irq, event_trigger;
	logic ladder_power, ladder_pin_drive, ladder_range, ladder_source;
	logic [3:0] ladder_level;
	int error_cnt = 0, check_count = 0, cycles = 0;
	int irq_cnt [2] = '{0, 0};
	always #5 clock = ~clock;
	dce_top i_dce_top (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .device_idle,
		.analog_result, .cmp_power, .cmp_low_power, .plus_select_ladder, .minus_select_one, .minus_select_two,
		.result_pin, .result_pin_oe, .ladder_power, .ladder_pin_drive, .ladder_range, .ladder_source,
		.ladder_level, .event_irq, .event_trigger);
	dce_analog_model i_dce_analog_model (.cmp_power, .plus_select_ladder, .minus_select_one, .minus_select_two,
		.ladder_power, .ladder_range, .ladder_source, .ladder_level, .pin_a, .pin_b(16'h8080),
		.pin_c(16'h2020), .pin_d(16'he0e0), .analog_result);
	always @(posedge clock) begin
		cycles <= cycles + 1;
		for (int i = 0; i < 2; i++)
			if (event_irq[i] === 1'b1) irq_cnt[i] <= irq_cnt[i] + 1;
		if (cycles == 4000) begin
			error_cnt++;
			results();
		end
	end
	task automatic chk(logic [15:0] seen, logic [15:0] exp, string msg);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: %s saw %h expected %h", $time, msg, seen, exp);
		end
	endtask
	task automatic wr(logic [1:0] a, logic [15:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask
	task automatic rd(logic [1:0] a, logic [15:0] exp, string msg);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 chk(reg_rdata, exp, msg);
	endtask
	task automatic t_regs();
		for (int a = 0; a < 4; a++)
			rd(2'(a), 16'h0000, "reset value");
		wr(dce_pkg::ADDR_SETUP_ONE, 16'h7cfc);
		#1 chk({10'h000, result_pin_oe[0], cmp_low_power[0], plus_select_ladder[0], cmp_power[0],
			minus_select_one}, 16'h0038, "setup outputs");
		rd(dce_pkg::ADDR_SETUP_ONE, 16'h70d0, "setup readback");
		for (int m = 0; m < 4; m++) begin
			wr(dce_pkg::ADDR_SETUP_TWO, 16'(m));
			#1 chk({14'h0000, minus_select_two}, 16'(m), "minus select");
		end
		wr(dce_pkg::ADDR_LADDER, 16'hffff);
		#1 chk({8'h00, ladder_power, ladder_pin_drive, ladder_range, ladder_source, ladder_level},
			16'h00ff, "ladder outputs");
		rd(dce_pkg::ADDR_LADDER, 16'h00ff, "ladder readback");
		wr(dce_pkg::ADDR_LADDER, 16'h0000);
		wr(dce_pkg::ADDR_SETUP_ONE, 16'h0000);
		wr(dce_pkg::ADDR_SETUP_TWO, 16'h0000);
		$display("registers done");
	endtask
	task automatic t_idle();
		wr(dce_pkg::ADDR_SETUP_ONE, 16'h8000);
		wr(dce_pkg::ADDR_STATUS, 16'h8000);
		device_idle <= 1'b1;
		repeat (6) @(posedge clock);
		#1 chk({15'h0000, cmp_power[0]}, 16'h0000, "idle stop");
		wr(dce_pkg::ADDR_STATUS, 16'h0000);
		#1 chk({15'h0000, cmp_power[0]}, 16'h0001, "idle run");
		@(posedge clock);
		device_idle <= 1'b0;
		wr(dce_pkg::ADDR_SETUP_ONE, 16'h0000);
		$display("idle done");
	endtask
	task automatic t_ladder();
		wr(dce_pkg::ADDR_LADDER, 16'h00af);
		wr(dce_pkg::ADDR_SETUP_ONE, 16'h8010);
		repeat (8) @(posedge clock);
		rd(dce_pkg::ADDR_SETUP_ONE, 16'h8110, "ladder above pin b");
		wr(dce_pkg::ADDR_LADDER, 16'h0000);
		repeat (8) @(posedge clock);
		rd(dce_pkg::ADDR_SETUP_ONE, 16'h8010, "ladder powered down");
		wr(dce_pkg::ADDR_SETUP_ONE, 16'h0000);
		$display("ladder done");
	endtask
	task automatic t_events();
		logic [15:0] cfg;
		int base;
		for (int c = 0; c < 2; c++)
			for (int e = 0; e < 4; e++)
				for (int p = 0; p < 2; p++) begin
					cfg = 16'h8000 | 16'(p << 13) | 16'(e << 6);
					wr(2'(c), cfg);
					repeat (8) @(posedge clock);
					wr(2'(c), cfg);
					repeat (8) @(posedge clock);
					base = irq_cnt[c];
					pin_a <= c ? 16'hc040 : 16'h40c0;
					#1 chk({15'h0000, result_pin[c]}, 16'(p ^ 1), "raw pin");
					repeat (10) @(posedge clock);
					rd(2'(c), cfg | 16'(((e & 1) << 9) | ((p ^ 1) << 8)), "flag after rise");
					@(posedge clock);
					pin_a <= 16'h4040;
					repeat (10) @(posedge clock);
					chk(16'(irq_cnt[c] - base), 16'(e != 0), "event count");
					rd(dce_pkg::ADDR_STATUS, 16'(((e != 0) << (8 + c)) | (p << c)), "mirrors");
					wr(2'(c), 16'h0000);
				end
		$display("events done");
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clock);
		rst_n <= 1'b1;
		t_regs();
		t_idle();
		t_ladder();
		t_events();
		results();
	end
endmodule
`default_nettype wire
